// ### include/lcq_regs.svh
`ifndef LCQ_REGS_SVH
`define LCQ_REGS_SVH

// ---------------------------------------------------------------------------
// register addresses
// ---------------------------------------------------------------------------
`define LCQ_ADDR_TX_LANE_CTL   16'ha011
`define LCQ_ADDR_RX_LANE_CTL   16'ha012
`define LCQ_ADDR_SQ_MODE       16'ha014
`define LCQ_ADDR_MON_SRC       16'ha015
`define LCQ_ADDR_MAN_SQ        16'ha040
`define LCQ_ADDR_COND_FIRST    16'ha440
`define LCQ_ADDR_COND_LAST     16'ha443

// ---------------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------------
`define LCQ_MON_RATE_HI        7
`define LCQ_MON_RATE_LO        5
`define LCQ_MON_SRC_HI         13
`define LCQ_MON_SRC_LO         12
`define LCQ_AUTO_SQ_BIT        9
`define LCQ_EQ_MODE_BIT        15
`define LCQ_EQ_GAIN_HI         12
`define LCQ_EQ_GAIN_LO         9
`define LCQ_EMPH_HI            3
`define LCQ_EMPH_LO            0

// ---------------------------------------------------------------------------
// reset values and codes
// ---------------------------------------------------------------------------
`define LCQ_MON_RATE_RST       3'h0
`define LCQ_MON_RATE_DIV8      3'h2
`define LCQ_MON_SRC_RST        2'h0
`define LCQ_MON_SRC_TX         2'h1
`define LCQ_AUTO_SQ_RST        1'h0
`define LCQ_MAN_SQ_RST         16'h0000
`define LCQ_EQ_MODE_RST        1'h0
`define LCQ_EQ_GAIN_RST        4'h0
`define LCQ_EMPH_RST           4'h0

// ---------------------------------------------------------------------------
// frame timing, in management clock bits
// ---------------------------------------------------------------------------
`define LCQ_PREAMBLE_BITS      6'h20
`define LCQ_BIT_HDR_LAST       6'h0d
`define LCQ_BIT_TURN           6'h0e
`define LCQ_BIT_FRAME_LAST     6'h1f

`endif

// ### include/lcq_pkg.sv
package lcq_pkg;

   typedef enum logic [2:0]
   {
      lcq_st_pre  = 3'b001,
      lcq_st_hdr  = 3'b010,
      lcq_st_data = 3'b100
   } lcq_state_t;

   typedef enum logic [1:0]
   {
      lcq_op_addr  = 2'b00,
      lcq_op_write = 2'b01,
      lcq_op_rinc  = 2'b10,
      lcq_op_read  = 2'b11
   } lcq_op_t;

   typedef logic [3:0] lcq_nibble_t;

endpackage : lcq_pkg

// ### rtl/lcq_sync.sv
`timescale 1ns/1ps

module lcq_sync
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] stage1;

   // the first stage feeds only the second one
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         stage1 <= '0;
         dout   <= '0;
      end
      else
      begin
         stage1 <= din;
         dout   <= stage1;
      end
   end

endmodule : lcq_sync

// ### rtl/lcq_top.sv
`timescale 1ns/1ps
`include "lcq_regs.svh"

// Overview of operation
// - tx and rx monitor-clock rate in bits 7:5; 000 off at reset, 010 is 1/8
// - monitor source: 00 off at reset, 01 routes tx monitor clock, 10/11 reserved
// - one conditioning register per host lane, bit 15: 0 automatic eq, 1 manual
// - eq gain bits 12:9 reset to zero; host writes 0 to 9 dB manually
// - bits 3:0 give rx emphasis of N half-decibels, zero at reset
// - squelch mode bit 9 set: each lane mutes while its signal loss is set
// - auto squelch off: manual register bit n mutes host lane n, zero at reset
module lcq_top
#(
   parameter logic [4:0] PORT_ADDR = 5'h00,
   parameter logic [4:0] DEV_ADDR  = 5'h01
)
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        mdc,
   input  wire logic        mdio_in,
   output logic             mdio_out,
   output logic             mdio_oe,
   input  wire logic [15:0] receive_signal_loss,
   input  wire logic [15:0] auto_eq_gain,
   output logic      [2:0]  tx_monitor_rate,
   output logic      [2:0]  rx_monitor_rate,
   output logic             monitor_clock_tx_sel,
   output logic             monitor_clock_div8,
   output logic      [15:0] rx_output_squelch,
   output logic      [15:0] eq_gain,
   output logic      [15:0] rx_emphasis
);
   import lcq_pkg::*;

   // ------------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------------
   logic        mdc_s;
   logic        mdio_s;
   logic [15:0] loss_s;
   logic        mdc_d;
   logic        mdc_rise;

   lcq_sync #(.WIDTH(18)) u_sync
   (
      .mclk                      (mclk),
      .rst                       (rst),
      .din                       ({mdc, mdio_in, receive_signal_loss}),
      .dout                      ({mdc_s, mdio_s, loss_s})
   );

   always_ff @(posedge mclk)
   begin
      if (rst)
         mdc_d <= 1'b0;
      else
         mdc_d <= mdc_s;
   end

   // both sides act on the rising edge; output changes well inside 300 ns
   assign mdc_rise = mdc_s & ~mdc_d;

   // ------------------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------------------
   logic [2:0]       tx_rate,  next_tx_rate;
   logic [2:0]       rx_rate,  next_rx_rate;
   logic             auto_sq,  next_auto_sq;
   logic [1:0]       mon_src,  next_mon_src;
   logic [15:0]      man_sq,   next_man_sq;
   logic [3:0]       eq_man,   next_eq_man;
   lcq_nibble_t      gain_w  [4];
   lcq_nibble_t      next_gain_w [4];
   lcq_nibble_t      emph    [4];
   lcq_nibble_t      next_emph [4];
   logic [15:0]      next_squelch;
   logic [15:0]      next_eq_gain;
   logic [15:0]      next_emphasis;

   logic             wr_en;
   logic [15:0]      wr_addr;
   logic [15:0]      wr_data;

   function automatic logic is_cond(input logic [15:0] a);
      is_cond = (a >= `LCQ_ADDR_COND_FIRST) && (a <= `LCQ_ADDR_COND_LAST);
   endfunction : is_cond

   function automatic logic [1:0] cond_lane(input logic [15:0] a);
      cond_lane = a[1:0];
   endfunction : cond_lane

   function automatic logic [15:0] rd_mux(input logic [15:0] a);
      logic [15:0] d;
      d = 16'h0000;
      if (a == `LCQ_ADDR_TX_LANE_CTL)
         d[`LCQ_MON_RATE_HI:`LCQ_MON_RATE_LO] = tx_rate;
      else if (a == `LCQ_ADDR_RX_LANE_CTL)
         d[`LCQ_MON_RATE_HI:`LCQ_MON_RATE_LO] = rx_rate;
      else if (a == `LCQ_ADDR_SQ_MODE)
         d[`LCQ_AUTO_SQ_BIT] = auto_sq;
      else if (a == `LCQ_ADDR_MON_SRC)
         d[`LCQ_MON_SRC_HI:`LCQ_MON_SRC_LO] = mon_src;
      else if (a == `LCQ_ADDR_MAN_SQ)
         d = man_sq;
      else if (is_cond(a))
      begin
         d[`LCQ_EQ_MODE_BIT] = eq_man[cond_lane(a)];
         d[`LCQ_EQ_GAIN_HI:`LCQ_EQ_GAIN_LO] = gain_w[cond_lane(a)];
         d[`LCQ_EMPH_HI:`LCQ_EMPH_LO] = emph[cond_lane(a)];
      end
      rd_mux = d;
   endfunction : rd_mux

   always_comb
   begin
      next_tx_rate = tx_rate;
      next_rx_rate = rx_rate;
      next_auto_sq = auto_sq;
      next_mon_src = mon_src;
      next_man_sq  = man_sq;
      next_eq_man  = eq_man;
      next_gain_w  = gain_w;
      next_emph    = emph;
      if (wr_en)
      begin
         if (wr_addr == `LCQ_ADDR_TX_LANE_CTL)
            next_tx_rate = wr_data[`LCQ_MON_RATE_HI:`LCQ_MON_RATE_LO];
         if (wr_addr == `LCQ_ADDR_RX_LANE_CTL)
            next_rx_rate = wr_data[`LCQ_MON_RATE_HI:`LCQ_MON_RATE_LO];
         if (wr_addr == `LCQ_ADDR_SQ_MODE)
            next_auto_sq = wr_data[`LCQ_AUTO_SQ_BIT];
         if (wr_addr == `LCQ_ADDR_MON_SRC)
            next_mon_src = wr_data[`LCQ_MON_SRC_HI:`LCQ_MON_SRC_LO];
         if (wr_addr == `LCQ_ADDR_MAN_SQ)
            next_man_sq = wr_data;
         if (is_cond(wr_addr))
         begin
            next_eq_man[cond_lane(wr_addr)] = wr_data[`LCQ_EQ_MODE_BIT];
            next_gain_w[cond_lane(wr_addr)] =
               wr_data[`LCQ_EQ_GAIN_HI:`LCQ_EQ_GAIN_LO];
            next_emph[cond_lane(wr_addr)] =
               wr_data[`LCQ_EMPH_HI:`LCQ_EMPH_LO];
         end
      end
      // lane muting follows signal loss only while auto squelch is on
      next_squelch = auto_sq ? loss_s : man_sq;
      for (int i = 0; i < 4; i++)
      begin
         // manual value held back until the lane is switched to manual
         next_eq_gain[4*i +: 4] = eq_man[i] ? gain_w[i]
                                            : auto_eq_gain[4*i +: 4];
         next_emphasis[4*i +: 4] = emph[i];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         tx_rate           <= `LCQ_MON_RATE_RST;
         rx_rate           <= `LCQ_MON_RATE_RST;
         auto_sq           <= `LCQ_AUTO_SQ_RST;
         mon_src           <= `LCQ_MON_SRC_RST;
         man_sq            <= `LCQ_MAN_SQ_RST;
         eq_man            <= {4{`LCQ_EQ_MODE_RST}};
         gain_w            <= '{default: `LCQ_EQ_GAIN_RST};
         emph              <= '{default: `LCQ_EMPH_RST};
         rx_output_squelch <= 16'h0000;
         eq_gain           <= 16'h0000;
         rx_emphasis       <= 16'h0000;
      end
      else
      begin
         tx_rate           <= next_tx_rate;
         rx_rate           <= next_rx_rate;
         auto_sq           <= next_auto_sq;
         mon_src           <= next_mon_src;
         man_sq            <= next_man_sq;
         eq_man            <= next_eq_man;
         gain_w            <= next_gain_w;
         emph              <= next_emph;
         rx_output_squelch <= next_squelch;
         eq_gain           <= next_eq_gain;
         rx_emphasis       <= next_emphasis;
      end
   end

   assign tx_monitor_rate      = tx_rate;
   assign rx_monitor_rate      = rx_rate;
   // reserved source codes keep the monitor clock off
   assign monitor_clock_tx_sel = (mon_src == `LCQ_MON_SRC_TX);
   assign monitor_clock_div8   = monitor_clock_tx_sel &&
                                 (tx_rate == `LCQ_MON_RATE_DIV8);

   // ------------------------------------------------------------------------
   // management frame engine
   // ------------------------------------------------------------------------
   lcq_state_t  state,     next_state;
   logic [5:0]  bit_cnt,   next_bit_cnt;
   logic [5:0]  pre_cnt,   next_pre_cnt;
   logic [15:0] shift,     next_shift;
   logic [15:0] out_shift, next_out_shift;
   logic [15:0] addr,      next_addr;
   lcq_op_t     op,        next_op;
   logic        hit,       next_hit;
   logic        next_mdio_out;
   logic        next_mdio_oe;
   logic [15:0] in_word;

   assign in_word = {shift[14:0], mdio_s};

   always_comb
   begin
      next_state     = state;
      next_bit_cnt   = bit_cnt;
      next_pre_cnt   = pre_cnt;
      next_shift     = shift;
      next_out_shift = out_shift;
      next_addr      = addr;
      next_op        = op;
      next_hit       = hit;
      next_mdio_out  = mdio_out;
      next_mdio_oe   = mdio_oe;
      wr_en          = 1'b0;
      wr_addr        = addr;
      wr_data        = in_word;
      if (mdc_rise)
      begin
         unique case (state)
            lcq_st_pre:
            begin
               if (mdio_s)
               begin
                  if (pre_cnt != `LCQ_PREAMBLE_BITS)
                     next_pre_cnt = pre_cnt + 6'h01;
               end
               else
               begin
                  // a zero after a full preamble is the first start bit
                  if (pre_cnt == `LCQ_PREAMBLE_BITS)
                  begin
                     next_state   = lcq_st_hdr;
                     next_bit_cnt = 6'h01;
                  end
                  next_pre_cnt = 6'h00;
               end
            end
            lcq_st_hdr:
            begin
               next_shift   = in_word;
               next_bit_cnt = bit_cnt + 6'h01;
               // second start bit high is a short-form frame: not ours
               if (bit_cnt == 6'h01 && mdio_s)
                  next_state = lcq_st_pre;
               else if (bit_cnt == `LCQ_BIT_HDR_LAST)
               begin
                  next_op    = lcq_op_t'(in_word[11:10]);
                  next_hit   = (in_word[9:5] == PORT_ADDR) &&
                               (in_word[4:0] == DEV_ADDR);
                  next_state = lcq_st_data;
               end
            end
            lcq_st_data:
            begin
               next_shift   = in_word;
               next_bit_cnt = bit_cnt + 6'h01;
               if (op[1] && hit)
               begin
                  if (bit_cnt == `LCQ_BIT_TURN)
                  begin
                     next_mdio_oe   = 1'b1;
                     next_mdio_out  = 1'b0;
                     next_out_shift = rd_mux(addr);
                  end
                  else if (bit_cnt != `LCQ_BIT_FRAME_LAST)
                  begin
                     next_mdio_out  = out_shift[15];
                     next_out_shift = {out_shift[14:0], 1'b0};
                  end
               end
               if (bit_cnt == `LCQ_BIT_FRAME_LAST)
               begin
                  next_mdio_oe  = 1'b0;
                  next_mdio_out = 1'b0;
                  next_state    = lcq_st_pre;
                  next_pre_cnt  = 6'h00;
                  if (hit)
                  begin
                     if (op == lcq_op_addr)
                        next_addr = in_word;
                     else if (op == lcq_op_write)
                        wr_en = 1'b1;
                     else if (op == lcq_op_rinc)
                        next_addr = addr + 16'h0001;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state     <= lcq_st_pre;
         bit_cnt   <= 6'h00;
         pre_cnt   <= 6'h00;
         shift     <= 16'h0000;
         out_shift <= 16'h0000;
         addr      <= 16'h0000;
         op        <= lcq_op_addr;
         hit       <= 1'b0;
         mdio_out  <= 1'b0;
         mdio_oe   <= 1'b0;
      end
      else
      begin
         state     <= next_state;
         bit_cnt   <= next_bit_cnt;
         pre_cnt   <= next_pre_cnt;
         shift     <= next_shift;
         out_shift <= next_out_shift;
         addr      <= next_addr;
         op        <= next_op;
         hit       <= next_hit;
         mdio_out  <= next_mdio_out;
         mdio_oe   <= next_mdio_oe;
      end
   end

endmodule : lcq_top

// ### tb/lcq_top_sva.sv
`timescale 1ns/1ps

// ------------------------
// port checks
// ------------------------
module lcq_top_sva
(
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic [15:0] auto_eq_gain,
   input wire logic [2:0]  tx_monitor_rate,
   input wire logic [2:0]  rx_monitor_rate,
   input wire logic        monitor_clock_tx_sel,
   input wire logic        monitor_clock_div8,
   input wire logic [15:0] rx_output_squelch,
   input wire logic [15:0] eq_gain,
   input wire logic [15:0] rx_emphasis
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   property p_div8;
      monitor_clock_div8 == (monitor_clock_tx_sel && tx_monitor_rate == 3'h2);
   endproperty
   a_div8: assert property (p_div8)
      else $error("div8 mismatch");

   property p_rate_rst;
      $fell(rst) |-> tx_monitor_rate == 3'h0 && rx_monitor_rate == 3'h0;
   endproperty
   a_rate_rst: assert property (p_rate_rst)
      else $error("rate not off");

   property p_src_rst;
      $fell(rst) |-> !monitor_clock_tx_sel && !monitor_clock_div8;
   endproperty
   a_src_rst: assert property (p_src_rst)
      else $error("source not off");

   // auto gain is not synchronised, so either sample may be the one taken
   property p_eq_auto;
      $fell(rst) |-> ##3
         (eq_gain == auto_eq_gain || eq_gain == $past(auto_eq_gain));
   endproperty
   a_eq_auto: assert property (p_eq_auto)
      else $error("gain not automatic");

   property p_gain_rst;
      $fell(rst) |-> eq_gain == 16'h0000;
   endproperty
   a_gain_rst: assert property (p_gain_rst)
      else $error("gain not zero");

   property p_emph_rst;
      $fell(rst) |-> (rx_emphasis == 16'h0000)[*8];
   endproperty
   a_emph_rst: assert property (p_emph_rst)
      else $error("emphasis not zero");

   property p_sq_auto_off;
      $fell(rst) |-> ##3 rx_output_squelch == 16'h0000;
   endproperty
   a_sq_auto_off: assert property (p_sq_auto_off)
      else $error("muted on loss");

   property p_sq_rst;
      $fell(rst) |-> rx_output_squelch == 16'h0000;
   endproperty
   a_sq_rst: assert property (p_sq_rst)
      else $error("mute not clear");
endmodule : lcq_top_sva

bind lcq_top lcq_top_sva u_sva
(
   .mclk(mclk),
   .rst(rst),
   .auto_eq_gain(auto_eq_gain),
   .tx_monitor_rate(tx_monitor_rate),
   .rx_monitor_rate(rx_monitor_rate),
   .monitor_clock_tx_sel(monitor_clock_tx_sel),
   .monitor_clock_div8(monitor_clock_div8),
   .rx_output_squelch(rx_output_squelch),
   .eq_gain(eq_gain),
   .rx_emphasis(rx_emphasis)
);

// ### tb/lcq_host.sv
`timescale 1ns/1ps

// ------------------------
// management host model
// ------------------------
module lcq_host
(
   input  wire logic mclk,
   input  wire logic mdio_out,
   input  wire logic mdio_oe,
   output logic      mdc,
   output logic      mdio_in
);
   logic       drv;
   logic       drv_en;
   logic [4:0] dev;
   int         half;

   // released wire rests high through its pull-up
   assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv : 1'b1);

   initial
   begin
      mdc = 1'b0;
      drv = 1'b1;
      drv_en = 1'b0;
      dev = 5'h01;
      half = 6;
   end

   task automatic bit_cyc(input logic d, output logic q);
      drv = d;
      repeat (half) @(posedge mclk);
      #1 mdc = 1'b1;
      q = mdio_in;
      repeat (half) @(posedge mclk);
      #1 mdc = 1'b0;
   endtask : bit_cyc

   // every frame carries its own preamble; reads release the wire at bit 14
   task automatic xfer(input logic [1:0] op, input logic [15:0] d,
                       output logic [15:0] q, output logic ta);
      logic [31:0] f;
      logic        b;
      f = {2'b00, op, 5'h00, dev, 2'b10, d};
      // one edge between frames, so the enable never flips twice at once
      @(posedge mclk);
      #1 drv_en = 1'b1;
      repeat (32) bit_cyc(1'b1, b);
      for (int i = 31; i >= 0; i--)
      begin
         if (op[1] && i == 17)
            drv_en = 1'b0;
         bit_cyc(f[i], b);
         if (i == 16)
            ta = b;
         q = {q[14:0], b};
      end
      drv_en = 1'b0;
   endtask : xfer
endmodule : lcq_host

// ### tb/lcq_top_tb.sv
`timescale 1ns/1ps

// ------------------------
// bench
// ------------------------
module lcq_top_tb;
   typedef struct {logic [15:0] a; logic [15:0] w; logic [15:0] r;} lcq_row_t;

   logic        mclk;
   logic        rst;
   logic        mdc;
   logic        mdio_in;
   logic        mdio_out;
   logic        mdio_oe;
   logic [15:0] receive_signal_loss;
   logic [15:0] auto_eq_gain;
   logic [2:0]  tx_monitor_rate;
   logic [2:0]  rx_monitor_rate;
   logic        monitor_clock_tx_sel;
   logic        monitor_clock_div8;
   logic [15:0] rx_output_squelch;
   logic [15:0] eq_gain;
   logic [15:0] rx_emphasis;
   logic [15:0] q;
   logic        ta;
   int          mismatches = 0;
   int          n_checks = 0;

   // gains written stay inside 0..9
   lcq_row_t rows [9] = '{
      '{16'ha011, 16'hffff, 16'h00e0},
      '{16'ha012, 16'h0040, 16'h0040},
      '{16'ha015, 16'hffff, 16'h3000},
      '{16'ha014, 16'hffff, 16'h0200},
      '{16'ha040, 16'ha5a5, 16'ha5a5},
      '{16'ha440, 16'hf3ff, 16'h920f},
      '{16'ha441, 16'h8001, 16'h8001},
      '{16'ha443, 16'h0a00, 16'h0a00},
      '{16'ha016, 16'hffff, 16'h0000}
   };

   lcq_top uut
   (
      .mclk(mclk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in),
      .mdio_out(mdio_out), .mdio_oe(mdio_oe),
      .receive_signal_loss(receive_signal_loss),
      .auto_eq_gain(auto_eq_gain), .tx_monitor_rate(tx_monitor_rate),
      .rx_monitor_rate(rx_monitor_rate),
      .monitor_clock_tx_sel(monitor_clock_tx_sel),
      .monitor_clock_div8(monitor_clock_div8),
      .rx_output_squelch(rx_output_squelch), .eq_gain(eq_gain),
      .rx_emphasis(rx_emphasis)
   );

   lcq_host host
   (
      .mclk(mclk), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
      .mdc(mdc), .mdio_in(mdio_in)
   );

   initial
      mclk = 1'b0;
   always #2.5 mclk = ~mclk;

   task automatic chk(input string nm, input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [15:0] a, d);
      host.xfer(2'b00, a, q, ta);
      host.xfer(2'b01, d, q, ta);
   endtask : wr

   task automatic rd(input logic [15:0] a, exp);
      host.xfer(2'b00, a, q, ta);
      host.xfer(2'b11, 16'h0000, q, ta);
      chk("turnaround", {15'h0, ta}, 16'h0000);
      chk("read", q, exp);
   endtask : rd

   task automatic do_reset;
      @(posedge mclk);
      #1 rst = 1'b1;
      repeat (10) @(posedge mclk);
      #1 rst = 1'b0;
      repeat (4) @(posedge mclk);
   endtask : do_reset

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict

   // a hang is cut short here
   initial
   begin
      repeat (90000) @(posedge mclk);
      mismatches++;
      give_verdict;
   end

   initial
   begin
      rst = 1'b1;
      receive_signal_loss = 16'h00f0;
      auto_eq_gain = 16'h4321;
      do_reset;
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, rows[i].r);
      end
      chk("mon", {tx_monitor_rate, rx_monitor_rate, monitor_clock_tx_sel,
          monitor_clock_div8}, 16'h00e8);
      wr(16'ha015, 16'h1000);
      wr(16'ha011, 16'h0040);
      chk("div8", {monitor_clock_tx_sel, monitor_clock_div8}, 16'h3);
      chk("auto_sq", rx_output_squelch, 16'h00f0);
      @(posedge mclk);
      #1 receive_signal_loss = 16'h8001;
      auto_eq_gain = 16'h7777;
      repeat (6) @(posedge mclk);
      chk("auto_sq2", rx_output_squelch, 16'h8001);
      chk("gain", eq_gain, 16'h7709);
      chk("emph", rx_emphasis, 16'h001f);
      wr(16'ha014, 16'h0000);
      chk("man_sq", rx_output_squelch, 16'ha5a5);
      wr(16'ha015, 16'h2000);
      chk("src_rsv", {14'h0, monitor_clock_tx_sel, monitor_clock_div8},
          16'h0000);
      wr(16'ha443, 16'h8a00);
      chk("gain_man", eq_gain, 16'h5709);
      // slow clock, read with post-increment over two lanes
      host.half = 20;
      host.xfer(2'b00, 16'ha440, q, ta);
      host.xfer(2'b10, 16'h0000, q, ta);
      chk("rinc0", q, 16'h920f);
      host.xfer(2'b10, 16'h0000, q, ta);
      chk("rinc1", q, 16'h8001);
      host.half = 6;
      // foreign device address must leave the register alone
      host.dev = 5'h02;
      wr(16'ha040, 16'h0000);
      host.dev = 5'h01;
      rd(16'ha040, 16'ha5a5);
      do_reset;
      chk("mon0", {tx_monitor_rate, rx_monitor_rate, monitor_clock_tx_sel,
          monitor_clock_div8}, 16'h0000);
      chk("sq0", rx_output_squelch, 16'h0000);
      chk("gain0", eq_gain, 16'h7777);
      chk("emph0", rx_emphasis, 16'h0000);
      rd(16'ha440, 16'h0000);
      give_verdict;
   end
endmodule : lcq_top_tb
